// file: src/tmc_pkg.sv
// constants, field layouts and the control word for the 16-bit timer/counter
// assumes one system clock at 100 MHz; no other clock domain
package tmc_pkg;
    // register map indices on the 3-bit software port
    localparam logic [2:0] TMC_OFS_CTRL = 3'h0;
    localparam logic [2:0] TMC_OFS_LOW = 3'h1;
    localparam logic [2:0] TMC_OFS_HIGH = 3'h2;
    localparam logic [2:0] TMC_OFS_STAT = 3'h3;
    localparam logic [2:0] TMC_OFS_AUX = 3'h4;
    // status register field positions
    localparam int TMC_STAT_FLAG = 0;
    localparam int TMC_STAT_IE = 1;
    // auxiliary register field position
    localparam int TMC_AUX_OSC = 0;
    // reset values
    localparam logic [7:0] TMC_CTRL_RST = 8'h00;
    localparam logic [15:0] TMC_COUNT_RST = 16'h0000;
    localparam logic [15:0] TMC_COUNT_MAX = 16'hFFFF;
    localparam logic [7:0] TMC_BYTE_ZERO = 8'h00;
    // compare mode that raises the special event trigger
    localparam logic [3:0] TMC_MODE_SPECIAL = 4'hB;
    // instruction clock: system clock divided by four
    localparam int TMC_CLK_PERIOD_NS = 10;
    localparam int TMC_INSTR_DIV = 4;
    localparam logic [1:0] TMC_INSTR_LAST = 2'(TMC_INSTR_DIV - 1);
    // prescaler widths and masks for 1:1, 1:2, 1:4, 1:8
    localparam int TMC_PS_W = 3;
    localparam logic [2:0] TMC_PS_M1 = 3'h0;
    localparam logic [2:0] TMC_PS_M2 = 3'h1;
    localparam logic [2:0] TMC_PS_M4 = 3'h3;
    localparam logic [2:0] TMC_PS_M8 = 3'h7;
    // capture timer select codes {hi, lo}
    localparam logic [1:0] TMC_SEL_OTHER = 2'h0;
    localparam logic [1:0] TMC_SEL_SPLIT = 2'h1;
    // pin drive: both shared pins released
    localparam logic [1:0] TMC_PINS_OFF = 2'h3;
    localparam logic [1:0] TMC_PINS_ZERO = 2'h0;

    // control word, bit 7 down to bit 0
    typedef struct packed {
        logic wide_access_enable;       // bit 7
        logic capture_timer_select_hi;  // bit 6
        logic [1:0] input_prescale_select; // bits 5-4
        logic capture_timer_select_lo;  // bit 3
        logic external_sync_disable;    // bit 2
        logic counter_clock_select;     // bit 1
        logic counter_run;              // bit 0
    } tmc_ctrl_s;

    // compare unit trigger inputs
    typedef struct packed {
        logic [3:0] mode;
        logic event_pulse;
    } tmc_cmp_s;
endpackage

// file: src/tmc_sync2.sv
// two-flop synchroniser for one level
// assumes the input may change at any time relative to clk
`timescale 1ns/1ns
module tmc_sync2
    import tmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    // first stage, read only by the second
    logic meta_reg;

    // ----------------------------------------
    // two stages
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// file: src/tmc_prescaler.sv
// selectable 1:1 to 1:8 divider of count ticks
// assumes tick_in is a one-cycle pulse in the clk domain
`timescale 1ns/1ns
module tmc_prescaler
    import tmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic [1:0] sel,
    input wire logic tick_in,
    output logic tick_out
);
    // running count of input ticks
    logic [TMC_PS_W-1:0] cnt_reg;
    // all-ones pattern for the chosen ratio
    logic [TMC_PS_W-1:0] mask;

    // ----------------------------------------
    // ratio decode
    // ----------------------------------------
    always_comb
    begin
        case (sel)
            2'h0: mask = TMC_PS_M1;
            2'h1: mask = TMC_PS_M2;
            2'h2: mask = TMC_PS_M4;
            default: mask = TMC_PS_M8;
        endcase
    end

    // pass every n-th tick
    assign tick_out = tick_in && ((cnt_reg & mask) == mask);

    // ----------------------------------------
    // counter; clear wins over a tick
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_reg <= '0;
        else if (clr)
            cnt_reg <= '0; // RL17
        else if (tick_in)
            cnt_reg <= cnt_reg + 1'b1; // RL9
    end

    a_ps_clear: assert property (@(posedge clk) disable iff (rst) clr |=> cnt_reg == '0) // RL17
        else $error("prescaler not cleared");
endmodule

// file: src/tmc_timer.sv
// 16-bit timer/counter with byte access, prescaler and trigger reset
// assumes software strobes last one cycle and never overlap;
// external and oscillator inputs are sampled on clk
`timescale 1ns/1ns

// Function
// RL1 - 16-bit count in readable, writable byte pair
// RL2 - timer, sync counter, async counter modes
// RL3 - clock select low: count instruction cycles
// RL4 - clock select high: count external rising edges
// RL5 - skip first rise until a fall seen
// RL6 - control bit 1 selects the clock source
// RL7 - sync disable bit bypasses input synchroniser
// RL8 - internal clock ignores the sync bit
// RL9 - prescale field bits 5-4: 1,2,4,8
// RL10 - run bit 0 advances or holds count
// RL11 - bit 7 selects single 16-bit access
// RL12 - bits 6,3 choose capture unit timer
// RL13 - code 01: this timer feeds unit two
// RL14 - oscillator on: pins input, read zero
// RL15 - special event trigger clears the count
// RL16 - wide mode buffers the high byte
// RL17 - only low byte writes clear prescaler
// RL18 - rollover sets flag; flag and enable interrupt
// RL19 - mode 1011 triggers; write wins, no flag
// RL20 - code 1x this timer, 00 other timer
// RL21 - reset clears all control bits
module tmc_timer
    import tmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic external_count_input,
    input wire logic osc_clk_in,
    input wire tmc_cmp_s cmp_first,
    input wire tmc_cmp_s cmp_second,
    input wire logic [1:0] port_direction_c,
    input wire logic [1:0] port_out_c,
    input wire logic [1:0] pins_in,
    output logic [1:0] pins_out,
    output logic [1:0] pins_oe_n,
    output logic [1:0] port_read_c,
    output logic first_unit_uses_this,
    output logic second_unit_uses_this,
    output logic overflow_irq
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    tmc_ctrl_s ctrl_reg;          // control word
    logic [15:0] count_reg;       // the counter itself
    logic [7:0] hi_buf_reg;       // wide-mode high byte buffer
    logic flag_reg;               // overflow flag
    logic ie_reg;                 // overflow interrupt enable
    logic osc_en_reg;             // secondary oscillator enable
    logic [1:0] phase_reg;        // instruction cycle phase
    logic prev_lvl_reg;           // last sampled source level
    logic armed_reg;              // fall seen since selection
    logic [7:0] rdata_reg;        // read answer

    // ----------------------------------------
    // decoded strobes
    // ----------------------------------------
    logic wr_ctrl, wr_low, wr_high, wr_stat, wr_aux;
    logic rd_low;
    logic cnt_write;              // any write to the counter
    logic trig;                   // special event trigger
    logic inst_tick;              // one per instruction cycle
    logic src_raw;                // chosen external source
    logic src_sync;               // synchronised copy
    logic lvl;                    // level used for edges
    logic ext_rise, ext_fall;     // edges of that level
    logic ext_tick;               // counted external edge
    logic ps_in, ps_out;          // prescaler in and out
    logic inc;                    // counter advances now
    logic [1:0] ccp_sel;          // capture timer select code

    assign wr_ctrl = wr && (addr == TMC_OFS_CTRL);
    assign wr_low = wr && (addr == TMC_OFS_LOW);
    assign wr_high = wr && (addr == TMC_OFS_HIGH);
    assign wr_stat = wr && (addr == TMC_OFS_STAT);
    assign wr_aux = wr && (addr == TMC_OFS_AUX);
    assign rd_low = rd && (addr == TMC_OFS_LOW);
    assign cnt_write = wr_low || wr_high;

    // trigger only from a unit in special event compare mode
    assign trig = (cmp_first.event_pulse && (cmp_first.mode == TMC_MODE_SPECIAL))
        || (cmp_second.event_pulse && (cmp_second.mode == TMC_MODE_SPECIAL)); // RL19

    // ----------------------------------------
    // control register
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl_reg <= tmc_ctrl_s'(TMC_CTRL_RST); // RL21
        else if (wr_ctrl)
            ctrl_reg <= tmc_ctrl_s'(wdata);
    end

    // ----------------------------------------
    // auxiliary register: oscillator enable
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            osc_en_reg <= 1'b0;
        else if (wr_aux)
            osc_en_reg <= wdata[TMC_AUX_OSC];
    end

    // ----------------------------------------
    // instruction clock phase, divide by four
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            phase_reg <= '0;
        else
            phase_reg <= phase_reg + 1'b1;
    end

    assign inst_tick = (phase_reg == TMC_INSTR_LAST); // RL3

    // ----------------------------------------
    // external source and its edges
    // ----------------------------------------
    // oscillator output replaces the count pin when enabled
    assign src_raw = osc_en_reg ? osc_clk_in : external_count_input; // RL4

    tmc_sync2 u_sync (
        .clk(clk),
        .rst(rst),
        .d(src_raw),
        .q(src_sync)
    );

    // bypass picks the raw level, async counter mode
    assign lvl = ctrl_reg.external_sync_disable ? src_raw : src_sync; // RL7
    assign ext_rise = lvl && !prev_lvl_reg;
    assign ext_fall = !lvl && prev_lvl_reg;

    // previous level for edge detection
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prev_lvl_reg <= 1'b0;
        else
            prev_lvl_reg <= lvl;
    end

    // arm only after a falling edge while external is chosen
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            armed_reg <= 1'b0;
        else if (!ctrl_reg.counter_clock_select)
            armed_reg <= 1'b0; // RL5
        else if (ext_fall)
            armed_reg <= 1'b1; // RL5
    end

    // first rise before any fall is not counted
    assign ext_tick = armed_reg && ext_rise; // RL5

    // ----------------------------------------
    // source select and prescaler
    // ----------------------------------------
    // internal clock ignores the sync bit entirely
    assign ps_in = ctrl_reg.counter_clock_select ? ext_tick : inst_tick; // RL6 RL8 RL2

    tmc_prescaler u_ps (
        .clk(clk),
        .rst(rst),
        .clr(wr_low),
        .sel(ctrl_reg.input_prescale_select),
        .tick_in(ps_in),
        .tick_out(ps_out)
    );

    // stopped counter holds its value
    assign inc = ctrl_reg.counter_run && ps_out; // RL10

    // ----------------------------------------
    // counter: write, then trigger, then count
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            count_reg <= TMC_COUNT_RST;
        else if (wr_low)
        begin
            // wide mode loads the high byte from the buffer
            count_reg[7:0] <= wdata; // RL1
            if (ctrl_reg.wide_access_enable)
                count_reg[15:8] <= hi_buf_reg; // RL16
        end
        else if (wr_high)
        begin
            // in wide mode the high write goes to the buffer
            if (!ctrl_reg.wide_access_enable)
                count_reg[15:8] <= wdata; // RL1 RL11
        end
        else if (trig)
            count_reg <= TMC_COUNT_RST; // RL15 RL19
        else if (inc)
            count_reg <= count_reg + 1'b1;
    end

    // ----------------------------------------
    // high byte buffer
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hi_buf_reg <= TMC_BYTE_ZERO;
        else if (wr_high && ctrl_reg.wide_access_enable)
            hi_buf_reg <= wdata; // RL16
        else if (rd_low && ctrl_reg.wide_access_enable)
            hi_buf_reg <= count_reg[15:8]; // RL16 RL11
    end

    // ----------------------------------------
    // overflow flag; hardware set wins over clear
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flag_reg <= 1'b0;
        else if (inc && !cnt_write && !trig && (count_reg == TMC_COUNT_MAX))
            flag_reg <= 1'b1; // RL18
        else if (wr_stat)
            flag_reg <= wdata[TMC_STAT_FLAG];
    end

    // interrupt enable bit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ie_reg <= 1'b0;
        else if (wr_stat)
            ie_reg <= wdata[TMC_STAT_IE];
    end

    assign overflow_irq = flag_reg && ie_reg; // RL18

    // ----------------------------------------
    // read port, answer one cycle later
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_reg <= TMC_BYTE_ZERO;
        else if (rd)
        begin
            case (addr)
                TMC_OFS_CTRL: rdata_reg <= ctrl_reg;
                TMC_OFS_LOW: rdata_reg <= count_reg[7:0]; // RL1
                // wide mode returns the buffer, not the live byte
                TMC_OFS_HIGH: rdata_reg <= ctrl_reg.wide_access_enable
                    ? hi_buf_reg : count_reg[15:8]; // RL16
                TMC_OFS_STAT:
                begin
                    rdata_reg <= TMC_BYTE_ZERO;
                    rdata_reg[TMC_STAT_FLAG] <= flag_reg;
                    rdata_reg[TMC_STAT_IE] <= ie_reg;
                end
                TMC_OFS_AUX:
                begin
                    rdata_reg <= TMC_BYTE_ZERO;
                    rdata_reg[TMC_AUX_OSC] <= osc_en_reg;
                end
                // unmapped addresses read zero
                default: rdata_reg <= TMC_BYTE_ZERO;
            endcase
        end
    end

    assign rdata = rdata_reg;

    // ----------------------------------------
    // capture unit time base selection
    // ----------------------------------------
    assign ccp_sel = {ctrl_reg.capture_timer_select_hi, ctrl_reg.capture_timer_select_lo}; // RL12
    // 1x: both units; 01: second only; 00: neither
    assign first_unit_uses_this = ccp_sel[1]; // RL20
    assign second_unit_uses_this = (ccp_sel != TMC_SEL_OTHER); // RL13 RL20

    // ----------------------------------------
    // shared oscillator pins
    // ----------------------------------------
    // oscillator forces inputs and zero reads
    assign pins_out = port_out_c;
    assign pins_oe_n = osc_en_reg ? TMC_PINS_OFF : port_direction_c; // RL14
    assign port_read_c = osc_en_reg ? TMC_PINS_ZERO : pins_in; // RL14

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_roll;
        inc && !cnt_write && !trig && (count_reg == TMC_COUNT_MAX);
    endsequence

    a_overflow_sets: assert property (s_roll |=> flag_reg && count_reg == TMC_COUNT_RST) // RL18
        else $error("rollover did not set flag");
    a_trig_clears: assert property (trig && !cnt_write |=> count_reg == TMC_COUNT_RST && !$rose(flag_reg)) // RL15
        else $error("trigger did not clear count");
    a_write_wins: assert property (wr_low && trig |=> count_reg[7:0] == $past(wdata)) // RL19
        else $error("trigger beat a write");
    a_stop_holds: assert property (!ctrl_reg.counter_run && !cnt_write && !trig |=> $stable(count_reg)) // RL10
        else $error("stopped counter moved");
    a_int_rate: assert property (!ctrl_reg.counter_clock_select && inc |-> phase_reg == TMC_INSTR_LAST) // RL3 RL8
        else $error("internal count off phase");
    a_first_edge: assert property (ctrl_reg.counter_clock_select && !armed_reg && !cnt_write && !trig // RL5
        |=> $stable(count_reg))
        else $error("first external edge counted");
    a_low_read: assert property (rd_low |=> rdata == $past(count_reg[7:0])) // RL1
        else $error("low byte read wrong");
    a_wide_latch: assert property (rd_low && ctrl_reg.wide_access_enable
        |=> hi_buf_reg == $past(count_reg[15:8])) // RL16
        else $error("high byte not buffered");
    a_pins_input: assert property (osc_en_reg |-> pins_oe_n == TMC_PINS_OFF && port_read_c == TMC_PINS_ZERO) // RL14
        else $error("oscillator pins not released");
    a_unit_select: assert property (ccp_sel == TMC_SEL_SPLIT |-> second_unit_uses_this && !first_unit_uses_this) // RL13
        else $error("unit select wrong");
    a_high_noclr: assert property (wr_high |=> u_ps.cnt_reg == TMC_PS_W'($past(u_ps.cnt_reg) + $past(ps_in))) // RL17
        else $error("high write touched prescaler");
endmodule

// file: testbench/tmc_ext_src.sv
// far-side model: external count pin or secondary oscillator
// assumes clk is the system clock; levels change just after its edges
`timescale 1ns/1ns
module tmc_ext_src
(
    input wire logic clk,
    input wire logic go,
    input wire logic use_osc,
    input wire logic [7:0] rises,
    input wire logic [3:0] half,
    output logic ext_out,
    output logic osc_out,
    output logic busy
);
    logic lvl; // level of the active source

    initial
    begin
        lvl = 1'b0;
        busy = 1'b0;
    end

    // the unused source stands still low
    assign ext_out = use_osc ? 1'b0 : lvl;
    assign osc_out = use_osc ? lvl : 1'b0;

    // burst of rising edges, each high then low for half cycles
    always @(posedge clk)
    begin
        if (go && !busy)
        begin
            busy <= 1'b1;
            for (int i = 0; i < rises; i++)
            begin
                lvl <= 1'b1;
                repeat (half) @(posedge clk);
                lvl <= 1'b0;
                repeat (half) @(posedge clk);
            end
            busy <= 1'b0;
        end
    end
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the 16-bit timer/counter
// assumes one 100 MHz clock and a far-side pulse model
`timescale 1ns/1ns
module tb_top
    import tmc_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk, rst, wr, rd, go, use_osc, busy, ext_in, osc_in;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    tmc_cmp_s cmp_first, cmp_second;
    logic [1:0] port_direction_c, port_out_c, pins_in, pins_out, pins_oe_n, port_read_c;
    logic first_sel, second_sel, irq;
    int fails, comparisons;

    tmc_timer u_tmc_timer (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .external_count_input(ext_in), .osc_clk_in(osc_in), .cmp_first(cmp_first),
        .cmp_second(cmp_second), .port_direction_c(port_direction_c), .port_out_c(port_out_c),
        .pins_in(pins_in), .pins_out(pins_out), .pins_oe_n(pins_oe_n), .port_read_c(port_read_c),
        .first_unit_uses_this(first_sel), .second_unit_uses_this(second_sel), .overflow_irq(irq));
    tmc_ext_src u_tmc_ext_src (.clk(clk), .go(go), .use_osc(use_osc), .rises(8'h05), .half(4'h3),
        .ext_out(ext_in), .osc_out(osc_in), .busy(busy));

    always #5 clk = ~clk;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic conclude();
        $display("counts: comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] q);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 q = rdata;
    endtask

    // compare event on one unit, optionally beside a low-byte write
    task automatic trig(input logic on_first, input logic [3:0] m, input logic with_wr);
        @(posedge clk);
        if (on_first)
            cmp_first <= {m, 1'b1};
        else
            cmp_second <= {m, 1'b1};
        addr <= TMC_OFS_LOW;
        wdata <= 8'h55;
        wr <= with_wr;
        @(posedge clk);
        cmp_first <= '0;
        cmp_second <= '0;
        wr <= 1'b0;
    endtask

    // bounded wait for the far side to finish its burst
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge clk);
        while (busy && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        if (busy)
        begin
            fails++;
            $display("mismatch partner idle expected 0 seen 1");
            conclude();
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] q;
        rd_reg(TMC_OFS_CTRL, q);
        chk("ctrl reset", TMC_CTRL_RST, q);
        rd_reg(TMC_OFS_HIGH, q);
        chk("high reset", 8'h00, q);
        rd_reg(3'h5, q);
        chk("unmapped read", 8'h00, q);
        chk("pin enable", 8'(port_direction_c), 8'(pins_oe_n));
        chk("pin read", 8'(pins_in), 8'(port_read_c));
        chk("pin out", 8'(port_out_c), 8'(pins_out));
        $display("test reset done");
    endtask

    task automatic t_bytes();
        logic [7:0] q;
        wr_reg(TMC_OFS_LOW, 8'h34);
        wr_reg(TMC_OFS_HIGH, 8'h12);
        repeat (20) @(posedge clk);
        rd_reg(TMC_OFS_LOW, q);
        chk("low byte held", 8'h34, q);
        rd_reg(TMC_OFS_HIGH, q);
        chk("high byte held", 8'h12, q);
        $display("test bytes done");
    endtask

    // 64 cycles between samples: 16 instruction ticks, divided by 1,2,4,8
    task automatic t_timer();
        logic [7:0] a, b;
        for (int p = 0; p < 4; p++)
        begin
            wr_reg(TMC_OFS_CTRL, {2'b00, 2'(p), 1'b0, p == 3, 2'b01});
            rd_reg(TMC_OFS_LOW, a);
            repeat (62) @(posedge clk);
            rd_reg(TMC_OFS_LOW, b);
            chk("timer ticks", 8'(16 >> p), b - a);
        end
        $display("test timer done");
    endtask

    // prescale 1:8 cleared by low write, not by high write
    task automatic t_prescale();
        logic [7:0] q;
        wr_reg(TMC_OFS_LOW, 8'h00);
        repeat (12) @(posedge clk);
        wr_reg(TMC_OFS_HIGH, 8'h00);
        rd_reg(TMC_OFS_LOW, q);
        chk("prescale early", 8'h00, q);
        repeat (22) @(posedge clk);
        rd_reg(TMC_OFS_LOW, q);
        chk("prescale eighth", 8'h01, q);
        wr_reg(TMC_OFS_CTRL, 8'h00);
        $display("test prescale done");
    endtask

    // five rises, the first skipped: sync pin, async pin, oscillator
    task automatic t_extern();
        logic [7:0] q;
        for (int m = 0; m < 3; m++)
        begin
            wr_reg(TMC_OFS_CTRL, 8'h00);
            wr_reg(TMC_OFS_AUX, 8'(m == 2));
            use_osc <= (m == 2);
            wr_reg(TMC_OFS_CTRL, m == 1 ? 8'h07 : 8'h03);
            wr_reg(TMC_OFS_LOW, 8'h00);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            wait_idle();
            repeat (4) @(posedge clk);
            rd_reg(TMC_OFS_LOW, q);
            chk("edges counted", 8'h04, q);
            if (m == 2)
            begin
                chk("osc pin enable", 8'h03, 8'(pins_oe_n));
                chk("osc pin read", 8'h00, 8'(port_read_c));
            end
        end
        wr_reg(TMC_OFS_AUX, 8'h00);
        use_osc <= 1'b0;
        wr_reg(TMC_OFS_CTRL, 8'h00);
        $display("test extern done");
    endtask

    task automatic t_wide();
        logic [7:0] q;
        wr_reg(TMC_OFS_CTRL, 8'h80);
        wr_reg(TMC_OFS_HIGH, 8'hAB);
        wr_reg(TMC_OFS_LOW, 8'hCD);
        wr_reg(TMC_OFS_CTRL, 8'h00);
        rd_reg(TMC_OFS_HIGH, q);
        chk("wide write high", 8'hAB, q);
        wr_reg(TMC_OFS_HIGH, 8'h11);
        wr_reg(TMC_OFS_CTRL, 8'h80);
        rd_reg(TMC_OFS_LOW, q);
        chk("wide read low", 8'hCD, q);
        rd_reg(TMC_OFS_HIGH, q);
        chk("wide read high", 8'h11, q);
        wr_reg(TMC_OFS_CTRL, 8'h00);
        $display("test wide done");
    endtask

    task automatic t_overflow();
        logic [7:0] q;
        wr_reg(TMC_OFS_HIGH, 8'hFF);
        wr_reg(TMC_OFS_LOW, 8'hFE);
        wr_reg(TMC_OFS_STAT, 8'h02);
        #1;
        chk("irq idle", 8'h00, 8'(irq));
        wr_reg(TMC_OFS_CTRL, 8'h01);
        repeat (12) @(posedge clk);
        wr_reg(TMC_OFS_CTRL, 8'h00);
        rd_reg(TMC_OFS_STAT, q);
        chk("flag set", 8'h03, q & 8'h03);
        chk("irq raised", 8'h01, 8'(irq));
        rd_reg(TMC_OFS_HIGH, q);
        chk("wrapped high", 8'h00, q);
        wr_reg(TMC_OFS_STAT, 8'h02);
        rd_reg(TMC_OFS_STAT, q);
        chk("flag cleared", 8'h02, q & 8'h03);
        chk("irq dropped", 8'h00, 8'(irq));
        $display("test overflow done");
    endtask

    task automatic t_trigger();
        logic [7:0] q;
        wr_reg(TMC_OFS_HIGH, 8'h12);
        trig(1'b0, 4'hA, 1'b0);
        rd_reg(TMC_OFS_HIGH, q);
        chk("other mode no reset", 8'h12, q);
        trig(1'b0, TMC_MODE_SPECIAL, 1'b0);
        rd_reg(TMC_OFS_HIGH, q);
        chk("trigger reset high", 8'h00, q);
        rd_reg(TMC_OFS_STAT, q);
        chk("trigger no flag", 8'h02, q & 8'h03);
        wr_reg(TMC_OFS_HIGH, 8'h12);
        trig(1'b1, TMC_MODE_SPECIAL, 1'b1);
        rd_reg(TMC_OFS_LOW, q);
        chk("write wins low", 8'h55, q);
        rd_reg(TMC_OFS_HIGH, q);
        chk("write wins high", 8'h12, q);
        $display("test trigger done");
    endtask

    task automatic t_select();
        logic [1:0] c;
        for (int i = 0; i < 4; i++)
        begin
            c = 2'(i);
            wr_reg(TMC_OFS_CTRL, {1'b0, c[1], 2'b00, c[0], 3'b000});
            #1;
            chk("first unit", 8'(c[1]), 8'(first_sel));
            chk("second unit", 8'(c[1] | c[0]), 8'(second_sel));
        end
        wr_reg(TMC_OFS_CTRL, 8'h00);
        $display("test select done");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        {wr, rd, go, use_osc} = 4'h0;
        addr = 3'h0;
        wdata = 8'h00;
        cmp_first = '0;
        cmp_second = '0;
        port_direction_c = 2'b01;
        port_out_c = 2'b10;
        pins_in = 2'b10;
        fails = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_bytes();
        t_timer();
        wr_reg(TMC_OFS_CTRL, 8'h31);
        t_prescale();
        t_extern();
        t_wide();
        t_overflow();
        t_trigger();
        t_select();
        conclude();
    end
endmodule
